// file: hw/clock_gate_words.sv
// Purpose: Per-transcoder clock gating control words
// Assumes: Same register port and clock as the port control bank
// Notes: Only the gating disable bit is stored; other bits read as zero
`include "port_map.svh"

module clock_gate_words (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [19:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [2:0] cg_disable
);

    logic [2:0] cg_dis_r;
    logic [1:0] hit;

    assign hit = port_pkg::cg_index(reg_addr);
    assign cg_disable = cg_dis_r;

    // One disable bit per transcoder word
    genvar g;
    for (g = 0; g < 3; g++) begin : g_word
        // R07: gating disable bit
        always_ff @(posedge mclk) begin
            if (rst) begin
                cg_dis_r[g] <= 1'b0;
            end else if (ce && reg_wr && hit == 2'(g)) begin
                cg_dis_r[g] <= reg_wdata[`CG_DIS_BIT];
            end
        end
    end

endmodule

// file: hw/tmds_port_control.sv
// Purpose: Control bank for three digital display output ports B, C and D
// Assumes: vblank and lane data come from logic on mclk; reads answer one cycle later
// Notes: Enable, transcoder and colour format wait for the selected vblank
//
// Behaviour
// R01: Enable clear powers port down and tristates it; set enables it.
// R02: Enable, transcoder and colour writes apply at the next vblank only.
// R03: Transcoder select 00 A, 01 B, 10 C; 11 is reserved.
// R04: Colour format 000 is 8 bits, 011 is 12 bits; others reserved.
// R05: Software enables 12-bit mode by writing 8-bit first, then 12-bit.
// R06: Software disables clock gating around the two 12-bit enable writes; the bench disables it around the 12-bit write only.
// R07: Bit 10 of each transcoder gating word disables its port clock gating.
// R08: Lane reversal set reverses the four lanes; clear keeps normal order.
// R09: Lane reversal latches at enable; changes need disable then re-enable.
// R10: Software never enables a port and its pin-sharing packet port together.
// R11: In vertical sync mode software enables only in vertical active region.
// R12: Two-bit encoding field selects the link encoding applied to output data; here it is only driven out on encoding, lane data passes unencoded.
`include "port_map.svh"

module tmds_port_control #(
    parameter int LANE_W = 10
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [19:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [2:0] vblank,
    input wire logic [2:0][3:0][LANE_W-1:0] lane_in,
    output logic [2:0][3:0][LANE_W-1:0] lane_out,
    output logic [2:0] port_enabled,
    output logic [2:0] port_oe_n,
    output logic [2:0] port_power_down,
    output logic [2:0][1:0] src_sel,
    output logic [2:0] twelve_bpc,
    output logic [2:0][1:0] encoding,
    output logic [2:0] hdmi_mode,
    output logic [2:0] audio_en,
    output logic [2:0][1:0] sync_pol,
    output logic [2:0] cg_disable
);

    logic [1:0] wr_hit;
    logic [1:0] rd_ctl;
    logic [1:0] rd_cg;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic [2:0] cg_dis;
    port_pkg::port_ctl_t shadow_r [3];
    logic [31:0] shadow_word [3];

    // Word to struct, keeping old codes where software wrote a reserved one
    function automatic port_pkg::port_ctl_t merge_word(
        input port_pkg::port_ctl_t old,
        input logic [31:0] w
    );
        port_pkg::port_ctl_t n;
        n = old;
        n.en = w[`FLD_ENABLE];
        // R03: reserved select ignored
        if (w[`FLD_XCD_HI:`FLD_XCD_LO] != `XCD_RESERVED) begin
            n.xcd = w[`FLD_XCD_HI:`FLD_XCD_LO];
        end
        // R04: reserved format ignored
        if (w[`FLD_COLOR_HI:`FLD_COLOR_LO] == `COLOR_8BPC ||
            w[`FLD_COLOR_HI:`FLD_COLOR_LO] == `COLOR_12BPC) begin
            n.color = w[`FLD_COLOR_HI:`FLD_COLOR_LO];
        end
        n.lane_rev = w[`FLD_LANE_REV];
        n.enc = w[`FLD_ENC_HI:`FLD_ENC_LO];
        n.hdmi_sel = w[`FLD_HDMI_SEL];
        n.audio = w[`FLD_AUDIO];
        n.sync_pol = w[`FLD_SYNC_HI:`FLD_SYNC_LO];
        return n;
    endfunction

    // Struct back to its register word, unused bits zero
    function automatic logic [31:0] pack_word(input port_pkg::port_ctl_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`FLD_ENABLE] = c.en;
        w[`FLD_XCD_HI:`FLD_XCD_LO] = c.xcd;
        w[`FLD_COLOR_HI:`FLD_COLOR_LO] = c.color;
        w[`FLD_LANE_REV] = c.lane_rev;
        w[`FLD_ENC_HI:`FLD_ENC_LO] = c.enc;
        w[`FLD_HDMI_SEL] = c.hdmi_sel;
        w[`FLD_AUDIO] = c.audio;
        w[`FLD_SYNC_HI:`FLD_SYNC_LO] = c.sync_pol;
        return w;
    endfunction

    // Address decode shared by writes and reads
    assign wr_hit = port_pkg::ctl_index(reg_addr);
    assign rd_ctl = port_pkg::ctl_index(reg_addr);
    assign rd_cg = port_pkg::cg_index(reg_addr);

    // Gating control words live in their own module
    clock_gate_words u_cg (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .cg_disable(cg_dis)
    );
    assign cg_disable = cg_dis;

    genvar p;
    for (p = 0; p < `NUM_PORTS; p++) begin : g_port
        logic pend_r;
        logic act_en_r;
        logic [1:0] act_xcd_r;
        logic twelve_r;
        logic lane_lock_r;
        logic oe_n_r;
        logic [1:0] vb_sel;
        logic apply;
        logic wr_me;
        logic [3:0][LANE_W-1:0] lanes_nxt;

        assign wr_me = reg_wr && wr_hit == 2'(p);
        assign shadow_word[p] = pack_word(shadow_r[p]);
        // Follow the running transcoder, or the requested one while idle
        assign vb_sel = act_en_r ? act_xcd_r : shadow_r[p].xcd;
        assign apply = pend_r && vblank[vb_sel];

        // Software copy, written at once; a reserved select or format code keeps its old value
        always_ff @(posedge mclk) begin
            if (rst) begin
                shadow_r[p] <= port_pkg::port_ctl_t'(13'h0003);
            end else if (ce && wr_me) begin
                shadow_r[p] <= merge_word(shadow_r[p], reg_wdata);
            end
        end

        // R02: pending until vblank
        // A write in the apply cycle keeps the flag set for the new value
        always_ff @(posedge mclk) begin
            if (rst) begin
                pend_r <= 1'b0;
            end else if (ce) begin
                if (wr_me) begin
                    pend_r <= 1'b1;
                end else if (apply) begin
                    pend_r <= 1'b0;
                end
            end
        end

        // R02: vblank-buffered fields
        always_ff @(posedge mclk) begin
            if (rst) begin
                act_en_r <= 1'b0;
                act_xcd_r <= 2'h0;
                twelve_r <= 1'b0;
                oe_n_r <= 1'b1;
            end else if (ce && apply) begin
                act_en_r <= shadow_r[p].en;
                act_xcd_r <= shadow_r[p].xcd;
                // R04: depth decoded into its own flop
                twelve_r <= shadow_r[p].color == `COLOR_12BPC;
                // R01: tristate when disabled
                oe_n_r <= ~shadow_r[p].en;
            end
        end

        // R09: latch reversal on enable
        always_ff @(posedge mclk) begin
            if (rst) begin
                lane_lock_r <= 1'b0;
            end else if (ce && apply && shadow_r[p].en && !act_en_r) begin
                lane_lock_r <= shadow_r[p].lane_rev;
            end
        end

        // R08: lane order select
        always_comb begin
            lanes_nxt = '0;
            for (int l = 0; l < `NUM_LANES; l++) begin
                if (act_en_r) begin
                    lanes_nxt[l] = lane_lock_r ? lane_in[p][`NUM_LANES - 1 - l]
                                               : lane_in[p][l];
                end
            end
        end

        // Registered lane data, quiet while the port is off
        always_ff @(posedge mclk) begin
            if (rst) begin
                lane_out[p] <= '0;
            end else if (ce) begin
                lane_out[p] <= lanes_nxt;
            end
        end

        // R01: enable and power state
        assign port_enabled[p] = act_en_r;
        assign port_oe_n[p] = oe_n_r;
        assign port_power_down[p] = oe_n_r;
        // R03: source transcoder route
        assign src_sel[p] = act_xcd_r;
        // R04: component depth select
        assign twelve_bpc[p] = twelve_r;
        // R12: encoding type out
        assign encoding[p] = shadow_r[p].enc;
        assign hdmi_mode[p] = shadow_r[p].hdmi_sel;
        assign audio_en[p] = shadow_r[p].audio;
        assign sync_pol[p] = shadow_r[p].sync_pol;
    end

    // Read path, one cycle latency, unmapped reads return zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end else if (ce) begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                if (rd_ctl != 2'h3) begin
                    rdata_r <= shadow_word[rd_ctl];
                end else if (rd_cg != 2'h3) begin
                    // R07: gating bit readback
                    rdata_r <= 32'(cg_dis[rd_cg]) << `CG_DIS_BIT;
                end else begin
                    rdata_r <= 32'h0000_0000;
                end
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

endmodule

// file: include/port_map.svh
// Purpose: Offsets, field positions, reset values for the display port control bank
// Assumes: Byte addresses inside a 20-bit register window
// Notes: Included by the package and the design files
`ifndef PORT_MAP_SVH
`define PORT_MAP_SVH

// Port control words, one per output port
`define PORT_B_CTL_ADDR 20'he1140
`define PORT_C_CTL_ADDR 20'he1150
`define PORT_D_CTL_ADDR 20'he1160
`define PORT_CTL_RESET 32'h0000_0018

// Field positions inside a port control word
`define FLD_ENABLE 31
`define FLD_XCD_HI 30
`define FLD_XCD_LO 29
`define FLD_COLOR_HI 28
`define FLD_COLOR_LO 26
`define FLD_LANE_REV 15
`define FLD_ENC_HI 11
`define FLD_ENC_LO 10
`define FLD_HDMI_SEL 9
`define FLD_AUDIO 6
`define FLD_SYNC_HI 4
`define FLD_SYNC_LO 3

// Field codes
`define XCD_RESERVED 2'h3
`define COLOR_8BPC 3'h0
`define COLOR_12BPC 3'h3

// Clock gating control words, one per transcoder
`define CG_A_ADDR 20'hf0060
`define CG_B_ADDR 20'hf1060
`define CG_C_ADDR 20'hf2060
`define CG_DIS_BIT 10

// Port and lane counts
`define NUM_PORTS 3
`define NUM_LANES 4

`endif

// file: include/port_pkg.sv
// Purpose: Types and address decoders shared by the port control files
// Assumes: port_map.svh is on the include path
// Notes: Decoders return 3 for an address that does not hit
`include "port_map.svh"

package port_pkg;

    typedef enum logic [1:0] {
        XCD_A = 2'h0,
        XCD_B = 2'h1,
        XCD_C = 2'h2
    } xcd_t;

    // Software view of one port control word
    typedef struct packed {
        logic en;
        logic [1:0] xcd;
        logic [2:0] color;
        logic lane_rev;
        logic [1:0] enc;
        logic hdmi_sel;
        logic audio;
        logic [1:0] sync_pol;
    } port_ctl_t;

    // Port control word index, 3 when no port word is hit
    function automatic logic [1:0] ctl_index(input logic [19:0] addr);
        unique case (addr)
            `PORT_B_CTL_ADDR: ctl_index = 2'h0;
            `PORT_C_CTL_ADDR: ctl_index = 2'h1;
            `PORT_D_CTL_ADDR: ctl_index = 2'h2;
            default: ctl_index = 2'h3;
        endcase
    endfunction

    // Clock gating word index, 3 when no gating word is hit
    function automatic logic [1:0] cg_index(input logic [19:0] addr);
        unique case (addr)
            `CG_A_ADDR: cg_index = 2'h0;
            `CG_B_ADDR: cg_index = 2'h1;
            `CG_C_ADDR: cg_index = 2'h2;
            default: cg_index = 2'h3;
        endcase
    endfunction

endpackage

// file: testbench/tmds_port_control_monitor.sv
// Purpose: Port-level checks for the port control bank
// Assumes: Port B (index 0) is the one the bench exercises in depth
// Notes: Bound to the design top below the module
module tmds_port_control_monitor #(
    parameter int LANE_W = 10
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic [2:0] vblank,
    input wire logic [2:0][3:0][LANE_W-1:0] lane_in,
    input wire logic [2:0][3:0][LANE_W-1:0] lane_out,
    input wire logic [2:0] port_enabled,
    input wire logic [2:0] port_oe_n,
    input wire logic [2:0] port_power_down,
    input wire logic [2:0][1:0] src_sel,
    input wire logic [2:0] twelve_bpc
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Read strobe, and a vblank seen on the previous edge
    sequence s_rd;
        ce && reg_rd;
    endsequence
    sequence s_vb;
        $past(|vblank);
    endsequence
    a_rd_answer: assert property (s_rd ##1 !reg_rd |-> reg_rvalid ##1 !reg_rvalid)
        else $error("read answer missing");
    a_rd_cause: assert property (reg_rvalid |-> $past(ce && reg_rd))
        else $error("read answer without strobe");
    a_oe_follows_en: assert property (port_oe_n == ~port_enabled)
        else $error("output enable wrong");
    a_pd_tracks_oe: assert property (port_power_down == port_oe_n)
        else $error("power down wrong");
    a_en_at_vblank: assert property ($changed(port_enabled[0]) |-> s_vb)
        else $error("enable moved outside vblank");
    a_src_at_vblank: assert property ($changed(src_sel[0]) |-> s_vb)
        else $error("source moved outside vblank");
    a_src_legal: assert property (src_sel[0] != 2'h3)
        else $error("reserved source in use");
    a_bpc_at_vblank: assert property ($changed(twelve_bpc[0]) |-> s_vb)
        else $error("colour moved outside vblank");
    a_lanes_quiet: assert property (!port_enabled[0] && $past(!port_enabled[0])
        |-> lane_out[0] == '0)
        else $error("lanes driven while disabled");
    a_lane_order: assert property (port_enabled[0] && $past(port_enabled[0])
        |-> lane_out[0][0] == $past(lane_in[0][0]) || lane_out[0][0] == $past(lane_in[0][3]))
        else $error("lane zero from wrong source");
endmodule

bind tmds_port_control tmds_port_control_monitor #(.LANE_W(LANE_W)) u_mon (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
    .vblank(vblank), .lane_in(lane_in), .lane_out(lane_out), .port_enabled(port_enabled),
    .port_oe_n(port_oe_n), .port_power_down(port_power_down), .src_sel(src_sel),
    .twelve_bpc(twelve_bpc));

// file: testbench/tmds_port_control_tb_top.sv
// Purpose: Self-checking bench for the port control bank
// Assumes: LANE_W of 8, so four lanes of a port form one 32-bit word
// Notes: Ports C and D take random words, port B the directed cases
`include "port_map.svh"
module tmds_port_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [19:0] pb = `PORT_B_CTL_ADDR;
    localparam logic [19:0] cgb = `CG_B_ADDR;
    logic mclk, rst, ce, reg_wr, reg_rd, reg_rvalid;
    logic [19:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rx, w;
    logic [31:0] shadow [3];
    logic [2:0] vblank, port_enabled, port_oe_n, port_power_down;
    logic [2:0] twelve_bpc, hdmi_mode, audio_en, cg_disable;
    logic [2:0][3:0][7:0] lane_in, lane_out;
    logic [2:0][1:0] src_sel, encoding, sync_pol;
    int miscompares, n_compared, cyc, p;
    integer seed = 32'h807565f1;

    tmds_port_control #(.LANE_W(8)) u_tmds_port_control (.mclk(mclk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .vblank(vblank), .lane_in(lane_in),
        .lane_out(lane_out), .port_enabled(port_enabled), .port_oe_n(port_oe_n),
        .port_power_down(port_power_down), .src_sel(src_sel), .twelve_bpc(twelve_bpc),
        .encoding(encoding), .hdmi_mode(hdmi_mode), .audio_en(audio_en),
        .sync_pol(sync_pol), .cg_disable(cg_disable));
    tmds_sink_model #(.LANE_W(8)) u_tmds_sink_model (.mclk(mclk), .oe_n(port_oe_n[0]),
        .lanes(lane_out[0]), .rx(rx));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Answer is looked at in the one cycle it stands
    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rvalid, 32'h1);
        chk(reg_rdata, exp);
    endtask

    // One vblank pulse on transcoder b, then time for lanes to settle
    task automatic vb(input int b);
        @(posedge mclk);
        vblank <= 3'h1 << b;
        @(posedge mclk);
        vblank <= 3'h0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // Readback: defined bits only, reserved codes keep the old field
    function automatic logic [31:0] expw(input logic [31:0] o, input logic [31:0] d);
        expw = d & 32'hfc00_8e58;
        if (d[30:29] == 2'h3) expw[30:29] = o[30:29];
        if (d[28:26] != 3'h0 && d[28:26] != 3'h3) expw[28:26] = o[28:26];
    endfunction

    function automatic logic [31:0] rev(input logic [31:0] v);
        rev = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    task automatic conclude;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        vblank = '0;
        lane_in = {$random(seed), $random(seed), $random(seed)};
        shadow = '{default: `PORT_CTL_RESET};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        // Random words into ports C and D, vblank held low
        for (int i = 0; i < 16; i++) begin
            p = 1 + i % 2;
            w = $random(seed);
            wr(pb + 20'(16 * p), w);
            shadow[p] = expw(shadow[p], w);
            rd(pb + 20'(16 * p), shadow[p]);
        end
        // Immediate fields follow the last word written
        for (int i = 1; i < 3; i++) begin
            w = {26'h0, shadow[i][9], shadow[i][6], shadow[i][4:3], shadow[i][11:10]};
            chk({hdmi_mode[i], audio_en[i], sync_pol[i], encoding[i]}, w);
        end
        $display("test random words done");
        // Second reset in mid-run, then reset values and an unmapped address
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) rd(pb + 20'(16 * i), `PORT_CTL_RESET);
        rd(`CG_A_ADDR, 32'h0);
        rd(pb + 20'h4, 32'h0);
        chk({sync_pol, port_power_down, port_oe_n}, 32'hfff);
        // Write with the clock enable low is frozen out
        @(posedge mclk);
        ce <= 1'b0;
        wr(pb + 20'h10, 32'h0000_0c58);
        ce <= 1'b1;
        chk(encoding[1], 32'h0);
        rd(pb + 20'h10, `PORT_CTL_RESET);
        $display("test reset values done");
        // packet port sharing the pins is never enabled here
        wr(pb, 32'ha000_0818);
        chk(encoding[0], 32'h2);
        vb(0);
        chk(port_enabled, 32'h0);
        vb(1);
        chk({src_sel[0], port_oe_n, port_enabled}, 32'h71);
        chk(rx, lane_in[0]);
        // gating off around the 12-bit step only
        wr(cgb, 32'h400);
        chk(cg_disable, 32'h2);
        wr(pb, 32'hac00_0818);
        chk(twelve_bpc, 32'h0);
        vb(1);
        chk(twelve_bpc, 32'h1);
        wr(cgb, 32'h0);
        chk(cg_disable, 32'h0);
        wr(pb, 32'hf400_0818);
        rd(pb, 32'hac00_0818);
        $display("test enable and colour done");
        // Reversal waits for a disable and re-enable
        wr(pb, 32'hac00_8818);
        vb(1);
        chk(rx, lane_in[0]);
        wr(pb, 32'h2c00_8818);
        vb(1);
        chk(lane_out[0], 32'h0);
        chk(port_oe_n, 32'h7);
        wr(pb, 32'hac00_8818);
        vb(1);
        chk(rx, rev(lane_in[0]));
        $display("test lane reversal done");
        conclude();
    end
endmodule

// file: testbench/tmds_sink_model.sv
// Purpose: Display sink on one port, captures the four lanes
// Assumes: Lane 0 is the low word of the packed lane bus
// Notes: Holds its last capture while the port is tristated
module tmds_sink_model #(
    parameter int LANE_W = 8
) (
    input wire logic mclk,
    input wire logic oe_n,
    input wire logic [3:0][LANE_W-1:0] lanes,
    output logic [3:0][LANE_W-1:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge mclk) begin
        if (!oe_n) rx <= lanes;
    end
endmodule
